// [rtl/usbdis_pkg.sv]
// Package for the device interrupt status block: register map, flag
// positions, reset values, pseudo frame timing and bus carrier types.
// Assumes a single 50 MHz controller clock.
package usbdis_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h18;
  localparam logic [DATA_W-1:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] STATUS_RSVD_MASK = 32'hFC00_0200;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

  // Flag positions
  localparam int BIT_BUS_RESET = 0;
  localparam int BIT_SOF = 1;
  localparam int BIT_INT_FRAME = 2;
  localparam int BIT_SUSPEND = 3;
  localparam int BIT_RESUME = 4;
  localparam int BIT_HS_CHANGE = 5;
  localparam int BIT_DMA = 6;
  localparam int BIT_VBUS = 7;
  localparam int BIT_SETUP = 8;
  localparam int BIT_EP_RX_BASE = 10;
  localparam int BIT_EP_TX_BASE = 11;
  localparam int NUM_EP = 8;

  // Pseudo frame timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int FRAME_FS_NS = 1000000;
  localparam int FRAME_HS_NS = 125000;
  localparam int FRAME_FS_CYCLES = FRAME_FS_NS / CLK_PERIOD_NS;
  localparam int FRAME_HS_CYCLES = FRAME_HS_NS / CLK_PERIOD_NS;
  localparam int FRAME_CNT_W = 32;

  localparam int DMA_REASON_W = 16;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } usbdis_req_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] rdata;
  } usbdis_rsp_t;

endpackage

// [rtl/usbdis_status.sv]
// Device interrupt status register with its event capture and the
// interrupt line towards the external processor.
// Assumes event inputs come from logic on clk; only the supply-voltage
// level arrives from a pin and is synchronised here.
`timescale 1ns/10ps
`default_nettype none

module usbdis_status
  import usbdis_pkg::*;
#(
  parameter int FS_FRAME_CYCLES = usbdis_pkg::FRAME_FS_CYCLES,
  parameter int HS_FRAME_CYCLES = usbdis_pkg::FRAME_HS_CYCLES,
  parameter int DMA_W = usbdis_pkg::DMA_REASON_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire usbdis_pkg::usbdis_req_t bus_req,
  output usbdis_pkg::usbdis_rsp_t bus_rsp,
  output logic irq,
  input wire logic [usbdis_pkg::NUM_EP-1:0] ep_tx_evt,
  input wire logic [usbdis_pkg::NUM_EP-1:0] ep_rx_evt,
  input wire logic setup_evt,
  input wire logic vbus_pin,
  input wire logic [DMA_W-1:0] dma_reason,
  input wire logic high_speed,
  input wire logic suspended,
  input wire logic sof_evt,
  input wire logic bus_reset_evt,
  output logic [usbdis_pkg::DATA_W-1:0] status_flags
);
  import usbdis_pkg::*;

  generate
    if (FS_FRAME_CYCLES < 2 || HS_FRAME_CYCLES < 2 || DMA_W < 1) begin : g_bad_param
      $error("usbdis_status: frame counts must be at least 2 and DMA width at least 1");
    end
    if (BIT_EP_RX_BASE + 2*NUM_EP > DATA_W) begin : g_bad_ep
      $error("usbdis_status: endpoint flags do not fit the status word");
    end
  endgenerate

  localparam logic [FRAME_CNT_W-1:0] FS_LAST = FRAME_CNT_W'(FS_FRAME_CYCLES - 1);
  localparam logic [FRAME_CNT_W-1:0] HS_LAST = FRAME_CNT_W'(HS_FRAME_CYCLES - 1);

  function automatic logic hit(input usbdis_req_t r);
    hit = (r.addr == STATUS_OFFSET);
  endfunction

  logic [DATA_W-1:0] flags_r;
  logic [DATA_W-1:0] flags_nxt;
  logic [DATA_W-1:0] set_vec;
  logic [DATA_W-1:0] clr_vec;
  logic vbus_s1_r;
  logic vbus_s2_r;
  logic vbus_d_r;
  logic suspend_flag_d_r;
  logic hs_d_r;
  logic [DMA_W-1:0] dma_d_r;
  logic [FRAME_CNT_W-1:0] frame_cnt_r;
  logic frame_tick;
  usbdis_rsp_t rsp_r;
  logic [2*NUM_EP-1:0] ep_field;
  logic wr_hit;
  logic rd_hit;
  logic ev_vbus;
  logic ev_dma;
  logic ev_hs;
  logic ev_resume;
  logic ev_suspend;

  // Pin synchroniser; only the second stage is looked at
  always_ff @(posedge clk) begin
    if (rst) begin
      vbus_s1_r <= 1'b0;
      vbus_s2_r <= 1'b0;
    end else begin
      vbus_s1_r <= vbus_pin;
      vbus_s2_r <= vbus_s1_r;
    end
  end

  // History of levels for change detection
  always_ff @(posedge clk) begin
    if (rst) begin
      vbus_d_r <= 1'b0;
      suspend_flag_d_r <= 1'b0;
      hs_d_r <= 1'b0;
      dma_d_r <= '0;
    end else begin
      vbus_d_r <= vbus_s2_r;
      suspend_flag_d_r <= suspended;
      hs_d_r <= high_speed;
      dma_d_r <= dma_reason;
    end
  end

  // Internal frame marker, free of bus SOF; counter cleared and tick off while suspended
  // since no frames are expected then, restarted by bus reset.
  assign frame_tick = !suspended &&
    (frame_cnt_r >= (high_speed ? HS_LAST : FS_LAST));

  always_ff @(posedge clk) begin
    if (rst || bus_reset_evt || suspended) begin
      frame_cnt_r <= '0;
    end else if (frame_tick) begin
      frame_cnt_r <= '0;
    end else begin
      frame_cnt_r <= frame_cnt_r + FRAME_CNT_W'(1);
    end
  end

  // Decoded once, shared by clear and read paths
  assign wr_hit = bus_req.wr && hit(bus_req);
  assign rd_hit = bus_req.rd && hit(bus_req);

  // Level changes; histories reset low, so a level already high at
  // release reports as an edge one cycle later.
  assign ev_vbus = vbus_s2_r ^ vbus_d_r;
  assign ev_dma = (dma_reason != dma_d_r);
  // Speed change ignored during suspend, so a full-speed suspend
  // cannot raise the high-speed flag.
  assign ev_hs = high_speed && !hs_d_r && !suspended;
  assign ev_resume = !suspended && suspend_flag_d_r;
  assign ev_suspend = suspended && !suspend_flag_d_r;

  // Endpoint pairs, receive on the even bit and transmit on the odd;
  // index 0 is the control endpoint.
  generate
    for (genvar g = 0; g < NUM_EP; g++) begin : g_ep
      assign ep_field[2*g] = ep_rx_evt[g];
      assign ep_field[2*g+1] = ep_tx_evt[g];
    end
  endgenerate

  // Event collection into flag positions
  always_comb begin
    set_vec = '0;
    set_vec[BIT_BUS_RESET] = bus_reset_evt;
    set_vec[BIT_SOF] = sof_evt;
    set_vec[BIT_INT_FRAME] = frame_tick;
    set_vec[BIT_SUSPEND] = ev_suspend;
    set_vec[BIT_RESUME] = ev_resume;
    set_vec[BIT_HS_CHANGE] = ev_hs;
    set_vec[BIT_DMA] = ev_dma;
    set_vec[BIT_VBUS] = ev_vbus;
    set_vec[BIT_SETUP] = setup_evt;
    set_vec[BIT_EP_RX_BASE +: 2*NUM_EP] = ep_field;
    set_vec = set_vec & ~STATUS_RSVD_MASK;
  end

  // Write-one-to-clear; bus reset sweeps everything but its own flag.
  // New events win over any clear in the same cycle.
  always_comb begin
    clr_vec = '0;
    if (wr_hit) begin
      clr_vec = bus_req.wdata & ~STATUS_RSVD_MASK;
    end
    if (bus_reset_evt) begin
      clr_vec = clr_vec | ~(DATA_W'(1) << BIT_BUS_RESET);
    end
    flags_nxt = ((flags_r & ~clr_vec) | set_vec) & ~STATUS_RSVD_MASK;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_r <= STATUS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Read port, answers one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_r <= '0;
    end else begin
      rsp_r.valid <= bus_req.rd;
      if (bus_req.rd) begin
        rsp_r.rdata <= rd_hit ? flags_r : UNMAPPED_READ;
      end
    end
  end

  assign bus_rsp = rsp_r;
  assign status_flags = flags_r;
  assign irq = |flags_r;

endmodule // usbdis_status

`default_nettype wire

// [bench/usbdis_monitor.sv]
// Checker on the status block ports.
// Bound to usbdis_status; one clock.
`timescale 1ns/10ps
`default_nettype none
module usbdis_monitor
  import usbdis_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire usbdis_pkg::usbdis_req_t bus_req,
  input wire usbdis_pkg::usbdis_rsp_t bus_rsp,
  input wire logic irq,
  input wire logic setup_evt,
  input wire logic suspended,
  input wire logic sof_evt,
  input wire logic bus_reset_evt,
  input wire logic [DATA_W-1:0] status_flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic wr_st = bus_req.wr && bus_req.addr == STATUS_OFFSET;
  wire logic rd_st = bus_req.rd && bus_req.addr == STATUS_OFFSET;
  a_irq_any: assert property (irq == |status_flags) else $error("irq");
  a_rsvd_zero: assert property ((status_flags & STATUS_RSVD_MASK) == '0) else $error("rsvd");
  a_sof_set: assert property (sof_evt |=> status_flags[1]) else $error("sof");
  a_setup_set: assert property (setup_evt |=> status_flags[8]) else $error("setup");
  a_brst_set: assert property (bus_reset_evt |=> status_flags[0] && irq) else $error("brst");
  a_brst_clr: assert property (bus_reset_evt && !sof_evt |=> !status_flags[1]) else $error("bclr");
  a_suspend_flag_set: assert property ($rose(suspended) |=> status_flags[3]) else $error("suspend_flag");
  a_w1c_clr: assert property (wr_st && bus_req.wdata[1] && !sof_evt |=> !status_flags[1]) else $error("w1c");
  a_rd_data: assert property (rd_st |=> bus_rsp.valid && bus_rsp.rdata == $past(status_flags))
    else $error("rd");
endmodule // usbdis_monitor
bind usbdis_status usbdis_monitor i_usbdis_monitor (.clk, .rst, .bus_req, .bus_rsp, .irq,
  .setup_evt, .suspended, .sof_evt, .bus_reset_evt, .status_flags);
`default_nettype wire

// [bench/usbdis_cpu.sv]
// Processor model reading and clearing flags.
// Drives the strobe port 1 ns after the rising edge.
`timescale 1ns/10ps
`default_nettype none
module usbdis_cpu
  import usbdis_pkg::*;
(
  input wire logic clk,
  input wire usbdis_pkg::usbdis_rsp_t bus_rsp,
  output var usbdis_pkg::usbdis_req_t bus_req
);
  initial bus_req = '0;
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk) #1;
    bus_req = '{wr: w, rd: !w, addr: a, wdata: d & ~STATUS_RSVD_MASK};
    @(posedge clk) #1;
    bus_req = '0;
    q = bus_rsp.rdata;
  endtask
endmodule // usbdis_cpu
`default_nettype wire

// [bench/usbdis_status_tb.sv]
// Testbench for the status block.
// Short frame counts; processor model does register access.
`timescale 1ns/10ps
`default_nettype none
module usbdis_status_tb;
  import usbdis_pkg::*;
  logic clk, rst, setup_evt, vbus_pin, high_speed, suspended, sof_evt, bus_reset_evt, irq;
  logic [7:0] ep_tx_evt, ep_rx_evt;
  logic [15:0] dma_reason;
  logic [31:0] q, status_flags;
  wire usbdis_req_t bus_req;
  usbdis_rsp_t bus_rsp;
  int n_fail, cmp_count;
  usbdis_status #(.FS_FRAME_CYCLES(20), .HS_FRAME_CYCLES(8)) i_usbdis_status (.clk, .rst, .bus_req,
    .bus_rsp, .irq, .ep_tx_evt, .ep_rx_evt, .setup_evt, .vbus_pin, .dma_reason, .high_speed,
    .suspended, .sof_evt, .bus_reset_evt, .status_flags);
  usbdis_cpu i_usbdis_cpu (.clk, .bus_rsp, .bus_req);
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task automatic cyc(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d fails %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_ep;
    for (int i = 0; i < 8; i++) begin
      ep_tx_evt = 8'h01 << i;
      ep_rx_evt = 8'h01 << i;
      cyc(1);
      {ep_tx_evt, ep_rx_evt} = '0;
      chk("ep_set", 32'h8 | (32'h3 << (2 * i + 10)), status_flags);
      i_usbdis_cpu.acc(1'b1, STATUS_OFFSET, 32'h3 << (2 * i + 10), q);
      chk("ep_clr", 32'h8, status_flags);
    end
    $display("t_ep done");
  endtask
  task automatic t_misc;
    {setup_evt, sof_evt, high_speed, vbus_pin} = 4'hF;
    dma_reason = 16'h0001;
    cyc(1);
    {setup_evt, sof_evt} = 2'h0;
    cyc(4);
    chk("evts", 32'h1CA, status_flags);
    i_usbdis_cpu.acc(1'b0, STATUS_OFFSET, '0, q);
    chk("rd", 32'h1CA, q);
    i_usbdis_cpu.acc(1'b0, 8'h1C, '0, q);
    chk("unmapped", 32'h0, q);
    {high_speed, suspended} = 2'h0;
    cyc(1);
    high_speed = 1;
    cyc(1);
    chk("hs_res", 32'h1FA, status_flags & ~32'h4);
    dma_reason = 16'h0000;
    cyc(1);
    i_usbdis_cpu.acc(1'b1, STATUS_OFFSET, 32'h40, q);
    chk("dma_clr", 32'h0, status_flags & 32'h40);
    $display("t_misc done");
  endtask
  task automatic t_brst;
    bus_reset_evt = 1;
    cyc(1);
    bus_reset_evt = 0;
    chk("brst", 32'h1, status_flags);
    i_usbdis_cpu.acc(1'b1, STATUS_OFFSET, 32'hFFFFFFFF, q);
    chk("clr_all", 32'h0, {status_flags[31:1], irq});
    cyc(9);
    chk("tick", 32'h4, status_flags);
    $display("t_brst done");
  endtask
  initial begin
    {rst, setup_evt, vbus_pin, high_speed, suspended, sof_evt, bus_reset_evt} = 7'h40;
    {ep_tx_evt, ep_rx_evt, dma_reason} = '0;
    n_fail = 0;
    cmp_count = 0;
    cyc(20);
    chk("rst", 32'h0, status_flags);
    {rst, suspended} = 2'h1;
    cyc(1);
    chk("suspend_flag", 32'h8, status_flags);
    t_ep;
    t_misc;
    t_brst;
    print_verdict;
  end
  initial begin
    #20000;
    n_fail++;
    print_verdict;
  end
endmodule // usbdis_status_tb
`default_nettype wire
